// file: hdl/cycle_timing_pkg.sv
// constants, instruction classes and helpers shared by the timing control block
package cycle_timing_pkg;

   // ----------------------------------------------------------------
   // instruction classes
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      CLS_SINGLE_CYCLE,     // alu, extend, bit field, reverse, hint, clz
      CLS_LOAD_STORE,       // single word/half/byte load or store
      CLS_LOAD_TO_PC,       // single load into program counter
      CLS_MULTIPLE,         // ldm/stm/push/pop/doubleword, 1 + N
      CLS_MULTIPLE_PC,      // pop or ldm including program counter
      CLS_EXCLUSIVE_LOAD,
      CLS_EXCLUSIVE_STORE,
      CLS_MONITOR_CLEAR,
      CLS_BRANCH_COND,      // conditional and compare-with-zero branches
      CLS_BRANCH,           // unconditional, link, exchange, state switch
      CLS_TABLE_BRANCH,
      CLS_WRITE_PC,         // mov/add into program counter
      CLS_SPECIAL,          // cps/mrs/msr, 1 or 2
      CLS_WAIT,             // wait for event/interrupt, 1 + W
      CLS_BARRIER,          // 1 + B
      CLS_SIGNED_DIVIDE,
      CLS_UNSIGNED_DIVIDE,
      CLS_MUL_HIGH          // all six most-significant-word multiplies
   } instr_class_e;

   // ----------------------------------------------------------------
   // timing counts in core cycles
   // ----------------------------------------------------------------
   localparam logic [5:0] BASE_CYCLES       = 6'h01;
   localparam logic [5:0] MEM_SINGLE_CYCLES = 6'h02;
   localparam logic [5:0] TABLE_CYCLES      = 6'h02;
   localparam logic [5:0] SPECIAL_SLOW      = 6'h02;
   localparam logic [1:0] REFILL_MIN        = 2'h1;
   localparam logic [1:0] REFILL_MAX        = 2'h3;
   localparam logic [3:0] DIV_MIN_CYCLES    = 4'h2;
   localparam logic [3:0] DIV_MAX_CYCLES    = 4'hC;
   localparam int         REG_LIST_W        = 16;

   // number of registers set in a transfer list, pc and lr included
   function automatic logic [4:0] list_count(input logic [REG_LIST_W-1:0] regs);
      logic [4:0] n;
      n = 5'h00;
      for (int i = 0; i < REG_LIST_W; i++) begin
         n = n + {4'h0, regs[i]};
      end
      return n;
   endfunction : list_count

   // leading run of equal bits (ones or zeroes) in a word
   function automatic logic [5:0] lead_run(input logic [31:0] v);
      logic [5:0] n;
      logic       stop;
      n    = 6'h00;
      stop = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         if (!stop && v[i] == v[31]) begin
            n = n + 6'h01;
         end else begin
            stop = 1'b1;
         end
      end
      return n;
   endfunction : lead_run

endpackage : cycle_timing_pkg

// file: hdl/divide_cycle_calc.sv
// cycle count of an early-terminating divide from operand leading bits
module divide_cycle_calc
   import cycle_timing_pkg::*;
(
   input  wire logic        isSigned,
   input  wire logic [31:0] dividend,
   input  wire logic [31:0] divisor,
   output logic      [3:0]  cycles
);

   // ----------------------------------------------------------------
   // quotient width estimate
   // ----------------------------------------------------------------
   logic [5:0] runN;
   logic [5:0] runD;
   logic [5:0] sigN;
   logic [5:0] sigD;
   logic [5:0] qBits;
   logic [5:0] steps;

   // unsigned operands count leading zeroes only
   always_comb begin
      runN = lead_run(dividend);
      runD = lead_run(divisor);
      if (!isSigned && dividend[31]) runN = 6'h00;
      if (!isSigned && divisor[31])  runD = 6'h00;
      sigN  = 6'h20 - runN;
      sigD  = 6'h20 - runD;
      qBits = (sigN > sigD) ? sigN - sigD : 6'h00;
      // roughly three quotient bits retire per cycle
      steps = (qBits + 6'h02) / 6'h03;
      if (steps > 6'(DIV_MAX_CYCLES - DIV_MIN_CYCLES)) begin
         cycles = DIV_MAX_CYCLES;
      end else begin
         cycles = DIV_MIN_CYCLES + steps[3:0];
      end
   end

endmodule : divide_cycle_calc

// file: hdl/instr_cycle_timing.sv
// execution cycle count and busy control for one issued instruction
// What this block does
// - divide ends early; cycles follow leading zeroes of operands, and leading ones too when signed.
// - push, with or without return address register, takes one plus N cycles.
// - branch_link_state_switch takes one cycle plus refill penalty.
// - halfword_byte_swap completes in one cycle.
// - sign_extend_half takes one cycle.
// - mul_high_accumulate takes one cycle.
// - mul_high_subtract takes one cycle.
// - mul_high takes one cycle.
// - mul_high_accumulate_rounded takes one cycle.
// - mul_high_subtract_rounded takes one cycle.
// - mul_high_rounded takes one cycle.
// - refill penalty is one to three cycles by alignment, width, speculation.
// - N counts every listed register, program counter and return address included.
// - a single load or store directly following another completes in one cycle.
// - untaken conditional branch takes one cycle; taken adds refill penalty.
module instr_cycle_timing
   import cycle_timing_pkg::*;
(
   input  wire logic                  clock,
   input  wire logic                  rst,
   input  wire logic                  issueValid,
   input  wire instr_class_e          issueClass,
   input  wire logic [REG_LIST_W-1:0] regList,
   input  wire logic                  branchTaken,
   input  wire logic                  targetUnaligned,
   input  wire logic                  targetWide,
   input  wire logic                  addrSpeculated,
   input  wire logic                  specialSlow,
   input  wire logic [3:0]            barrierCycles,
   input  wire logic                  waitRelease,
   input  wire logic [31:0]           operandA,
   input  wire logic [31:0]           operandB,
   output logic                       issueReady,
   output logic                       retire,
   output logic [5:0]                 lastCycles
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {IDLE, COUNT, WAIT} phase_e;

   phase_e     phase_q;
   logic [5:0] remain_q;
   logic [5:0] spent_q;
   logic       prevMem_q;
   logic       issueReady_q;
   logic       retire_q;
   logic [5:0] lastCycles_q;

   logic [5:0] cycles_d;
   logic [1:0] refill;
   logic [3:0] divCycles;
   logic [5:0] listN;
   logic       accept;

   assign accept     = issueValid && issueReady_q;
   assign issueReady = issueReady_q;
   assign retire     = retire_q;
   assign lastCycles = lastCycles_q;

   // ----------------------------------------------------------------
   // divide estimate
   // ----------------------------------------------------------------
   divide_cycle_calc u_div (
      .isSigned (issueClass == CLS_SIGNED_DIVIDE),
      .dividend (operandA),
      .divisor  (operandB),
      .cycles   (divCycles)
   );

   // ----------------------------------------------------------------
   // refill penalty and list size
   // ----------------------------------------------------------------
   // speculation hides most of the refill; misaligned wide targets cost most
   always_comb begin
      if (addrSpeculated) begin
         refill = REFILL_MIN;
      end else if (targetUnaligned && targetWide) begin
         refill = REFILL_MAX;
      end else begin
         refill = REFILL_MIN + 2'h1;
      end
      listN = {1'b0, list_count(regList)};
   end

   // ----------------------------------------------------------------
   // cycle count per class
   // ----------------------------------------------------------------
   always_comb begin
      cycles_d = BASE_CYCLES;
      unique case (issueClass)
         CLS_SINGLE_CYCLE:    cycles_d = BASE_CYCLES;
         CLS_MUL_HIGH:        cycles_d = BASE_CYCLES;
         CLS_MONITOR_CLEAR:   cycles_d = BASE_CYCLES;
         CLS_LOAD_STORE: begin
            // pipelined behind a prior single access, the address phase is hidden
            cycles_d = prevMem_q ? BASE_CYCLES : MEM_SINGLE_CYCLES;
         end
         CLS_LOAD_TO_PC:      cycles_d = MEM_SINGLE_CYCLES + {4'h0, refill};
         CLS_MULTIPLE:        cycles_d = BASE_CYCLES + listN;
         CLS_MULTIPLE_PC:     cycles_d = BASE_CYCLES + listN + BASE_CYCLES;
         CLS_EXCLUSIVE_LOAD,
         CLS_EXCLUSIVE_STORE: cycles_d = MEM_SINGLE_CYCLES;
         CLS_BRANCH_COND: begin
            cycles_d = branchTaken ? BASE_CYCLES + {4'h0, refill} : BASE_CYCLES;
         end
         CLS_BRANCH:          cycles_d = BASE_CYCLES + {4'h0, refill};
         CLS_WRITE_PC:        cycles_d = BASE_CYCLES + {4'h0, refill};
         CLS_TABLE_BRANCH:    cycles_d = TABLE_CYCLES + {4'h0, refill};
         CLS_SPECIAL:         cycles_d = specialSlow ? SPECIAL_SLOW : BASE_CYCLES;
         CLS_WAIT:            cycles_d = BASE_CYCLES;
         CLS_BARRIER:         cycles_d = BASE_CYCLES + {2'h0, barrierCycles};
         CLS_SIGNED_DIVIDE,
         CLS_UNSIGNED_DIVIDE: cycles_d = {2'h0, divCycles};
         default:             cycles_d = BASE_CYCLES;
      endcase
   end

   // ----------------------------------------------------------------
   // execution sequencer
   // ----------------------------------------------------------------
   // one instruction in flight; ready drops while a multi-cycle one runs
   always_ff @(posedge clock) begin
      if (rst) begin
         phase_q      <= IDLE;
         remain_q     <= 6'h00;
         spent_q      <= 6'h00;
         issueReady_q <= 1'b1;
         retire_q     <= 1'b0;
         lastCycles_q <= 6'h00;
      end else begin
         retire_q <= 1'b0;
         unique case (phase_q)
            IDLE: begin
               if (accept) begin
                  spent_q <= 6'h01;
                  if (issueClass == CLS_WAIT && !waitRelease) begin
                     phase_q      <= WAIT;
                     issueReady_q <= 1'b0;
                  end else if (cycles_d == BASE_CYCLES) begin
                     retire_q     <= 1'b1;
                     lastCycles_q <= BASE_CYCLES;
                  end else begin
                     phase_q      <= COUNT;
                     remain_q     <= cycles_d - 6'h01;
                     issueReady_q <= 1'b0;
                  end
               end
            end
            COUNT: begin
               spent_q  <= spent_q + 6'h01;
               remain_q <= remain_q - 6'h01;
               if (remain_q == 6'h01) begin
                  phase_q      <= IDLE;
                  issueReady_q <= 1'b1;
                  retire_q     <= 1'b1;
                  lastCycles_q <= spent_q + 6'h01;
               end
            end
            WAIT: begin
               // count saturates; long sleeps report the ceiling
               if (spent_q != 6'h3F) spent_q <= spent_q + 6'h01;
               if (waitRelease) begin
                  phase_q      <= IDLE;
                  issueReady_q <= 1'b1;
                  retire_q     <= 1'b1;
                  lastCycles_q <= (spent_q == 6'h3F) ? spent_q : spent_q + 6'h01;
               end
            end
            default: phase_q <= IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // memory access adjacency
   // ----------------------------------------------------------------
   // only back-to-back single accesses pipeline; any other accepted class breaks it
   always_ff @(posedge clock) begin
      if (rst) begin
         prevMem_q <= 1'b0;
      end else if (accept) begin
         prevMem_q <= (issueClass == CLS_LOAD_STORE);
      end else if (phase_q == IDLE) begin
         prevMem_q <= 1'b0;
      end
   end

endmodule : instr_cycle_timing

// file: verification/instr_cycle_timing_chk.sv
// assertion checker for the instruction cycle timing block
module instr_cycle_timing_chk
   import cycle_timing_pkg::*;
(
   input wire logic                  clock,
   input wire logic                  rst,
   input wire logic                  issueValid,
   input wire instr_class_e          issueClass,
   input wire logic [REG_LIST_W-1:0] regList,
   input wire logic                  branchTaken,
   input wire logic                  targetUnaligned,
   input wire logic                  targetWide,
   input wire logic                  addrSpeculated,
   input wire logic                  issueReady,
   input wire logic                  retire,
   input wire logic [5:0]            lastCycles
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic                  take;
   logic [5:0]            elapsed_q;
   logic [5:0]            penD;
   logic [5:0]            pen_q;
   instr_class_e          cls_q;
   logic [REG_LIST_W-1:0] list_q;
   logic                  taken_q;
   // --------------------------------------------------------------
   // helper state: elapsed cycles and what was issued
   // --------------------------------------------------------------
   assign take = issueValid && issueReady;
   assign penD = addrSpeculated ? 6'h01 : ((targetUnaligned && targetWide) ? 6'h03 : 6'h02);
   // saturates like the reported count, so long waits still compare
   always_ff @(posedge clock) begin
      if (rst) begin
         elapsed_q <= 6'h00;
      end else if (take) begin
         elapsed_q <= 6'h01;
      end else if (elapsed_q != 6'h3F) begin
         elapsed_q <= elapsed_q + 6'h01;
      end
   end
   // issue attributes, held until the next accepted issue
   always_ff @(posedge clock) begin
      if (take) begin
         cls_q   <= issueClass;
         list_q  <= regList;
         taken_q <= branchTaken;
         pen_q   <= penD;
      end
   end
   // --------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------
   elapsed_match_a: assert property (retire |-> lastCycles == elapsed_q)
      else $error("reported count differs from elapsed cycles");
   list_count_a: assert property (retire && cls_q == CLS_MULTIPLE |->
      lastCycles == 6'($countones(list_q)) + 6'h01) else $error("multiple count wrong");
   list_pc_a: assert property (retire && cls_q == CLS_MULTIPLE_PC |->
      lastCycles == 6'($countones(list_q)) + 6'h02) else $error("pc multiple count wrong");
   branch_refill_a: assert property (retire && cls_q == CLS_BRANCH |->
      lastCycles == pen_q + 6'h01) else $error("branch count wrong");
   cond_branch_a: assert property (retire && cls_q == CLS_BRANCH_COND |->
      lastCycles == (taken_q ? pen_q + 6'h01 : 6'h01)) else $error("conditional count wrong");
   pc_write_a: assert property (retire && cls_q == CLS_WRITE_PC |->
      lastCycles == pen_q + 6'h01) else $error("counter write count wrong");
   refill_two_a: assert property (retire &&
      cls_q inside {CLS_LOAD_TO_PC, CLS_TABLE_BRANCH} |-> lastCycles == pen_q + 6'h02)
      else $error("two plus refill count wrong");
   mul_high_a: assert property (
      take && issueClass == CLS_MUL_HIGH |=>
      retire && issueReady && lastCycles == 6'h01) else $error("high multiply not one cycle");
   single_cycle_a: assert property (
      take && issueClass inside {CLS_SINGLE_CYCLE, CLS_MONITOR_CLEAR} |=>
      retire && lastCycles == 6'h01) else $error("single cycle op slow");
   excl_two_a: assert property (
      take && issueClass inside {CLS_EXCLUSIVE_LOAD, CLS_EXCLUSIVE_STORE} |=>
      !issueReady && !retire ##1 retire && lastCycles == 6'h02) else $error("exclusive not two");
   divide_range_a: assert property (
      retire && cls_q inside {CLS_SIGNED_DIVIDE, CLS_UNSIGNED_DIVIDE} |->
      lastCycles inside {[6'h02:6'h0C]}) else $error("divide count out of range");
endmodule : instr_cycle_timing_chk

bind instr_cycle_timing instr_cycle_timing_chk instr_cycle_timing_chk_i (.clock, .rst, .issueValid,
   .issueClass, .regList, .branchTaken, .targetUnaligned, .targetWide, .addrSpeculated,
   .issueReady, .retire, .lastCycles);

// file: verification/fetch_target_model.sv
// far-side model giving the fetch attributes of a branch target
module fetch_target_model
(
   input  wire logic [1:0] targetMode,
   output logic            targetUnaligned,
   output logic            targetWide,
   output logic            addrSpeculated
);
   timeunit 1ns;
   timeprecision 1ps;
   // 0 prompt speculated fetch, 1 plain refill, 2 slow unaligned wide target
   assign addrSpeculated  = (targetMode == 2'h0);
   assign targetUnaligned = (targetMode == 2'h2);
   assign targetWide      = targetMode[1];
endmodule : fetch_target_model

// file: verification/tb_top.sv
// self-checking bench for the instruction cycle timing block
module tb_top
   import cycle_timing_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0, rst = 1'b1, issueValid = 1'b0, branchTaken = 1'b0;
   logic specialSlow = 1'b0, waitRelease = 1'b0, issueReady, retire;
   logic targetUnaligned, targetWide, addrSpeculated;
   logic [1:0] targetMode = 2'h0;
   logic [3:0] barrierCycles = 4'h0;
   logic [5:0] lastCycles;
   logic [15:0] regList = 16'h0000;
   logic [31:0] operandA = 32'h00000001, operandB = 32'h00000001;
   instr_class_e issueClass = CLS_SINGLE_CYCLE;
   int err_count = 0, n_tests = 0;
   // 25 MHz core clock
   always #20 clock = ~clock;
   fetch_target_model fetch_target_model_i (.targetMode, .targetUnaligned, .targetWide,
      .addrSpeculated);
   instr_cycle_timing instr_cycle_timing_i (.clock, .rst, .issueValid, .issueClass, .regList,
      .branchTaken, .targetUnaligned, .targetWide, .addrSpeculated, .specialSlow,
      .barrierCycles, .waitRelease, .operandA, .operandB, .issueReady, .retire, .lastCycles);
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic complete_run();
      $display("tests %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run
   task automatic check(input logic [5:0] got, input logic [5:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
         err_count++;
      end
   endtask : check
   // issue one op from a falling edge, count edges until retire
   task automatic do_op(input instr_class_e c, input logic [5:0] exp);
      int n;
      // one idle edge first, so the strobe never falls and rises in one step
      @(negedge clock);
      issueClass = c;
      issueValid = 1'b1;
      @(negedge clock);
      issueValid = 1'b0;
      n = 1;
      while (retire !== 1'b1 && n < 80) begin
         @(negedge clock);
         n++;
      end
      if (n >= 80) begin
         err_count++;
         complete_run();
      end else begin
         check(6'(n), exp);
         check(lastCycles, exp);
      end
   endtask : do_op
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_single();
      issueClass = CLS_MUL_HIGH;
      issueValid = 1'b1;
      @(negedge clock);
      check({5'h00, retire}, 6'h01);
      @(negedge clock);
      issueValid = 1'b0;
      check({5'h00, retire}, 6'h01);
      check(lastCycles, 6'h01);
      do_op(CLS_SINGLE_CYCLE, 6'h01);
   endtask : t_single
   task automatic t_loadstore();
      do_op(CLS_LOAD_STORE, 6'h02);
      // strobe held: the second offer is refused while busy, later ones pipeline
      @(negedge clock);
      issueClass = CLS_LOAD_STORE;
      issueValid = 1'b1;
      repeat (2) @(negedge clock);
      check({5'h00, retire}, 6'h01);
      check(lastCycles, 6'h02);
      @(negedge clock);
      check({5'h00, retire}, 6'h01);
      check(lastCycles, 6'h01);
      @(negedge clock);
      issueValid = 1'b0;
      check({5'h00, retire}, 6'h01);
      check(lastCycles, 6'h01);
   endtask : t_loadstore
   task automatic t_multiple();
      regList = 16'h4003;
      do_op(CLS_MULTIPLE, 6'h04);
      regList = 16'h0001;
      do_op(CLS_MULTIPLE, 6'h02);
      regList = 16'hFFFF;
      do_op(CLS_MULTIPLE_PC, 6'h12);
   endtask : t_multiple
   task automatic t_branch();
      for (int m = 0; m < 3; m++) begin
         targetMode = 2'(m);
         do_op(CLS_BRANCH, 6'(m + 2));
      end
      do_op(CLS_BRANCH_COND, 6'h01);
      branchTaken = 1'b1;
      do_op(CLS_BRANCH_COND, 6'h04);
      branchTaken = 1'b0;
   endtask : t_branch
   task automatic t_excl_div();
      do_op(CLS_EXCLUSIVE_LOAD, 6'h02);
      do_op(CLS_EXCLUSIVE_STORE, 6'h02);
      do_op(CLS_MONITOR_CLEAR, 6'h01);
      do_op(CLS_SIGNED_DIVIDE, 6'h02);
      do_op(CLS_UNSIGNED_DIVIDE, 6'h02);
      operandA = 32'h7FFFFFFF;
      do_op(CLS_UNSIGNED_DIVIDE, 6'h0C);
      operandA = 32'h000000FF;
      do_op(CLS_SIGNED_DIVIDE, 6'h05);
      // all ones: a full-width signed run but no unsigned one
      operandA = 32'hFFFFFFFF;
      do_op(CLS_SIGNED_DIVIDE, 6'h02);
      do_op(CLS_UNSIGNED_DIVIDE, 6'h0C);
   endtask : t_excl_div
   task automatic t_refill_misc();
      targetMode = 2'h0;
      do_op(CLS_LOAD_TO_PC, 6'h03);
      do_op(CLS_WRITE_PC, 6'h02);
      targetMode = 2'h1;
      do_op(CLS_TABLE_BRANCH, 6'h04);
      do_op(CLS_SPECIAL, 6'h01);
      specialSlow = 1'b1;
      do_op(CLS_SPECIAL, 6'h02);
      specialSlow = 1'b0;
      barrierCycles = 4'h3;
      do_op(CLS_BARRIER, 6'h04);
      barrierCycles = 4'h0;
   endtask : t_refill_misc
   task automatic t_wait_reset();
      waitRelease = 1'b1;
      do_op(CLS_WAIT, 6'h01);
      @(negedge clock);
      waitRelease = 1'b0;
      issueClass = CLS_WAIT;
      issueValid = 1'b1;
      @(negedge clock);
      issueValid = 1'b0;
      repeat (4) @(negedge clock);
      check({4'h0, retire, issueReady}, 6'h00);
      waitRelease = 1'b1;
      @(negedge clock);
      check({4'h0, retire, issueReady}, 6'h03);
      check(lastCycles, 6'h06);
      // a load straight after the wait is not pipelined
      waitRelease = 1'b0;
      issueClass = CLS_LOAD_STORE;
      issueValid = 1'b1;
      @(negedge clock);
      issueValid = 1'b0;
      @(negedge clock);
      check({5'h00, retire}, 6'h01);
      check(lastCycles, 6'h02);
      // reset in mid-count must abort the long transfer
      @(negedge clock);
      issueClass = CLS_MULTIPLE;
      regList = 16'hFFFF;
      issueValid = 1'b1;
      @(negedge clock);
      issueValid = 1'b0;
      check({5'h00, issueReady}, 6'h00);
      @(negedge clock);
      rst = 1'b1;
      @(negedge clock);
      rst = 1'b0;
      check({4'h0, retire, issueReady}, 6'h01);
      check(lastCycles, 6'h00);
      do_op(CLS_MULTIPLE, 6'h11);
   endtask : t_wait_reset
   // main sequence: reset for 12 cycles, then every scenario
   initial begin
      repeat (12) @(negedge clock);
      rst = 1'b0;
      t_single();
      t_loadstore();
      t_multiple();
      t_branch();
      t_excl_div();
      t_refill_misc();
      t_wait_reset();
      complete_run();
   end
endmodule : tb_top
